// >>> alsi_top.sv
// Function lock, spindle speed, gear select and rigid tapping sequencer.
// Assumes an AHB-Lite master on hclk and a PLC whose inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none

module alsi_top (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  input  wire alsi_pkg::alsi_plc_in_t plc_in,
  output alsi_pkg::alsi_plc_out_t     plc_out
);

  // ==========================================================================
  // State
  typedef struct packed {
    alsi_pkg::alsi_fn_t      fn;
    alsi_pkg::alsi_tap_t     tap;
    logic [7:0]              ctrl;
    logic [16:0]             s_val;
    logic [16:0]             gmax1;
    logic [16:0]             gmax2;
    logic [16:0]             gmax3;
    logic                    tap_rev;
    logic                    done_seen;
    logic                    busy;
    logic                    ph_wr;
    logic [7:0]              ph_addr;
    logic                    rd_wait;
    logic                    hreadyout;
    logic [31:0]             hrdata;
    logic                    hresp;
    alsi_pkg::alsi_plc_out_t out;
  } alsi_state_t;

  alsi_state_t st_reg;
  alsi_state_t st_next;

  logic        bus_hit;
  logic        locked;
  logic        wr_cmd;
  logic        wr_tap;
  logic        wr_stat;
  logic        tap_step;
  logic        suppress;
  logic [1:0]  cmd_kind;
  logic [16:0] cmd_val;
  logic [7:0]  m_code;
  logic [6:0]  ovr_pct;
  logic [23:0] ovr_prod;
  logic [23:0] speed;
  logic [2:0]  gear_pick;
  logic [16:0] gmax_cur;
  logic [35:0] scaled;

  // ==========================================================================
  // Read multiplexer
  function automatic logic [31:0] read_mux(input alsi_state_t s,
                                           input logic [7:0] a,
                                           input alsi_pkg::alsi_plc_in_t p);
    logic [31:0] r;
    r = 32'h00000000;
    unique case (a)
      alsi_pkg::OFF_CTRL:      r = {24'h000000, s.ctrl};
      alsi_pkg::OFF_CMD:       r = {15'h0000, s.s_val};
      alsi_pkg::OFF_GMAX1:     r = {15'h0000, s.gmax1};
      alsi_pkg::OFF_GMAX2:     r = {15'h0000, s.gmax2};
      alsi_pkg::OFF_GMAX3:     r = {15'h0000, s.gmax3};
      alsi_pkg::OFF_STATUS:    r = {4'h0, s.out.analog, s.tap, 2'h0,
                                    p.gear_inpos, s.out.rigid, s.done_seen,
                                    s.out.lock_status, s.out.alarm, s.busy};
      alsi_pkg::OFF_TAP:       r = {29'h00000000, s.tap_rev, 1'b0,
                                    s.out.rigid};
      alsi_pkg::OFF_LOCK_BYTE: r = {28'h0000000, p.lock, 3'h0};
      alsi_pkg::OFF_GFB_BYTE:  r = {27'h0000000, p.gear_inpos, 1'b0,
                                    p.gear_fb};
      alsi_pkg::OFF_OVR_BYTE:  r = {26'h0000000,
                                    s.ctrl[alsi_pkg::CTRL_OVR_EN], 2'h0,
                                    p.ovr_code};
      alsi_pkg::OFF_STB_BYTE:  r = {28'h0000000, s.out.t_strobe,
                                    s.out.s_strobe, 1'b0, s.out.m_strobe};
      alsi_pkg::OFF_GSEL_BYTE: r = {29'h00000000, s.out.gear_sel};
      default:                 r = 32'h00000000;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Speed scaling and gear choice
  always_comb begin
    // Override only when enabled and no tapping or thread cutting
    if (st_reg.ctrl[alsi_pkg::CTRL_OVR_EN] &&
        !st_reg.ctrl[alsi_pkg::CTRL_TAPCYC] &&
        !st_reg.ctrl[alsi_pkg::CTRL_THREAD] &&
        st_reg.tap == alsi_pkg::TP_IDLE) begin
      ovr_pct = alsi_pkg::OVR_BASE +
                7'(alsi_pkg::OVR_STEP * {4'h0, plc_in.ovr_code});
    end else begin
      ovr_pct = alsi_pkg::OVR_FIXED;
    end
    ovr_prod = {7'h00, st_reg.s_val} * {17'h00000, ovr_pct};
    speed    = ovr_prod / alsi_pkg::PCT_DIV;
    // Lowest gear whose maximum covers the command, else the top gear (3 with CTRL_GEAR3, otherwise 2)
    if (hwdata[16:0] <= st_reg.gmax1) begin
      gear_pick = 3'h1;
    end else if (st_reg.ctrl[alsi_pkg::CTRL_GEAR3] &&
                 hwdata[16:0] <= st_reg.gmax2) begin
      gear_pick = 3'h2;
    end else if (st_reg.ctrl[alsi_pkg::CTRL_GEAR3]) begin
      gear_pick = 3'h4;
    end else begin
      gear_pick = 3'h2;
    end
    // Full scale follows the gear now on the outputs
    unique case (st_reg.out.gear_sel)
      3'h2:    gmax_cur = st_reg.gmax2;
      3'h4:    gmax_cur = st_reg.gmax3;
      default: gmax_cur = st_reg.gmax1;
    endcase
    if (gmax_cur == 17'h00000) begin
      scaled = 36'h000000000;
    end else begin
      scaled = ({12'h000, speed} * 36'h000000FFF) / {19'h00000, gmax_cur};
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_next  = st_reg;
    bus_hit  = hsel && hready && htrans[1];
    wr_cmd   = st_reg.ph_wr && st_reg.ph_addr == alsi_pkg::OFF_CMD;
    wr_tap   = st_reg.ph_wr && st_reg.ph_addr == alsi_pkg::OFF_TAP;
    wr_stat  = st_reg.ph_wr && st_reg.ph_addr == alsi_pkg::OFF_STATUS;
    tap_step = wr_tap && hwdata[alsi_pkg::TAP_STEP];
    cmd_kind = hwdata[29:28];
    cmd_val  = hwdata[16:0];
    m_code   = hwdata[7:0];
    locked   = plc_in.lock && (st_reg.ctrl[alsi_pkg::CTRL_AUTO] ||
                               st_reg.ctrl[alsi_pkg::CTRL_REMOTE] ||
                               st_reg.ctrl[alsi_pkg::CTRL_MANUAL]);
    suppress = 1'b0;

    // Bus address phase capture, one wait state on reads
    st_next.ph_wr   = bus_hit && hwrite;
    st_next.ph_addr = bus_hit ? haddr[7:0] : st_reg.ph_addr;
    st_next.hresp   = 1'b0;
    if (bus_hit && !hwrite) begin
      st_next.rd_wait   = 1'b1;
      st_next.hreadyout = 1'b0;
    end else if (st_reg.rd_wait) begin
      st_next.rd_wait   = 1'b0;
      st_next.hreadyout = 1'b1;
      st_next.hrdata    = read_mux(st_reg, st_reg.ph_addr, plc_in);
    end

    // Bus write data phase for plain registers
    if (st_reg.ph_wr) begin
      unique case (st_reg.ph_addr)
        alsi_pkg::OFF_CTRL:  st_next.ctrl  = hwdata[7:0];
        alsi_pkg::OFF_GMAX1: st_next.gmax1 = hwdata[16:0];
        alsi_pkg::OFF_GMAX2: st_next.gmax2 = hwdata[16:0];
        alsi_pkg::OFF_GMAX3: st_next.gmax3 = hwdata[16:0];
        default:             st_next.ctrl  = st_reg.ctrl;
      endcase
    end

    // Alarm: write one clears, a new alarm wins
    if (wr_stat && hwdata[alsi_pkg::ST_ALARM]) begin
      st_next.out.alarm = 1'b0;
    end

    // Function handshake with the PLC
    unique case (st_reg.fn)
      alsi_pkg::FN_IDLE: begin
        if (wr_cmd && !st_reg.busy) begin
          st_next.done_seen = 1'b0;
          unique case (cmd_kind)
            alsi_pkg::KIND_M: begin
              // M98 and M99 stay internal, lock spares M00 to M03
              suppress = (m_code == alsi_pkg::CODE_M98) ||
                         (m_code == alsi_pkg::CODE_M99) ||
                         (locked && m_code > alsi_pkg::CODE_M03);
              if (!suppress) begin
                st_next.out.m_code   = m_code;
                st_next.out.m_strobe = 1'b1;
                st_next.out.m_enc    = {m_code == alsi_pkg::CODE_M00,
                                        m_code == alsi_pkg::CODE_M01,
                                        m_code == alsi_pkg::CODE_M02,
                                        m_code == alsi_pkg::CODE_M30};
              end
            end
            alsi_pkg::KIND_S: begin
              if (st_reg.ctrl[alsi_pkg::CTRL_ANALOG]) begin
                // Analog value and gear move even when locked
                st_next.s_val        = cmd_val;
                st_next.out.gear_sel = gear_pick;
                suppress             = locked;
                st_next.out.s_strobe = !locked;
              end else if (cmd_val == 17'h00000 ||
                           cmd_val > alsi_pkg::S_GEAR_MAX) begin
                st_next.out.alarm = 1'b1;
                suppress          = 1'b1;
              end else begin
                suppress = locked;
                if (!locked) begin
                  st_next.out.s_gear   = 8'h01 << (cmd_val[2:0] - 3'h1);
                  st_next.out.s_strobe = 1'b1;
                end
              end
            end
            alsi_pkg::KIND_T: begin
              suppress = locked;
              if (!locked) begin
                st_next.out.t_code   = cmd_val[7:0];
                st_next.out.t_strobe = 1'b1;
              end
            end
            default: suppress = 1'b1;
          endcase
          if (suppress) begin
            st_next.done_seen = 1'b1;
          end else begin
            st_next.busy = 1'b1;
            st_next.fn   = alsi_pkg::FN_STROBE;
          end
        end
      end
      alsi_pkg::FN_STROBE: begin
        // Strobes hold until completion, lock changes nothing here
        if (plc_in.done) begin
          st_next.out.m_strobe = 1'b0;
          st_next.out.s_strobe = 1'b0;
          st_next.out.t_strobe = 1'b0;
          st_next.out.m_enc    = 4'h0;
          st_next.fn           = alsi_pkg::FN_RELEASE;
        end
      end
      alsi_pkg::FN_RELEASE: begin
        // Block may advance once completion has been seen and dropped
        if (!plc_in.done) begin
          st_next.busy      = 1'b0;
          st_next.done_seen = 1'b1;
          st_next.fn        = alsi_pkg::FN_IDLE;
        end
      end
    endcase

    // Analog speed output, forced low in gear mode
    if (!st_reg.ctrl[alsi_pkg::CTRL_ANALOG]) begin
      st_next.out.analog = 12'h000;
    end else if (scaled > {24'h000000, alsi_pkg::DAC_FULL}) begin
      st_next.out.analog = alsi_pkg::DAC_FULL;
    end else begin
      st_next.out.analog = scaled[11:0];
    end

    // Rigid tapping sequence
    unique case (st_reg.tap)
      alsi_pkg::TP_IDLE: begin
        if (wr_tap && hwdata[alsi_pkg::TAP_START]) begin
          st_next.tap_rev = hwdata[alsi_pkg::TAP_REVERSE];
          st_next.tap     = alsi_pkg::TP_ROT;
        end
      end
      alsi_pkg::TP_ROT:  st_next.tap = alsi_pkg::TP_FEED;
      alsi_pkg::TP_FEED: begin
        if (tap_step) begin
          st_next.tap = alsi_pkg::TP_STOP;
        end
      end
      alsi_pkg::TP_STOP: st_next.tap = alsi_pkg::TP_WAIT;
      alsi_pkg::TP_WAIT: begin
        if (plc_in.spindle_stopped) begin
          st_next.tap = alsi_pkg::TP_REV;
        end
      end
      alsi_pkg::TP_REV:  st_next.tap = alsi_pkg::TP_RET;
      alsi_pkg::TP_RET: begin
        if (tap_step) begin
          st_next.tap = alsi_pkg::TP_END;
        end
      end
      alsi_pkg::TP_END:  st_next.tap = alsi_pkg::TP_IDLE;
      default:           st_next.tap = alsi_pkg::TP_IDLE;
    endcase

    // Spindle command per tapping phase
    unique case (st_next.tap)
      alsi_pkg::TP_ROT, alsi_pkg::TP_FEED: begin
        st_next.out.spindle_cmd = st_next.tap_rev ? alsi_pkg::SPN_REV
                                                  : alsi_pkg::SPN_FWD;
      end
      alsi_pkg::TP_REV, alsi_pkg::TP_RET: begin
        st_next.out.spindle_cmd = st_next.tap_rev ? alsi_pkg::SPN_FWD
                                                  : alsi_pkg::SPN_REV;
      end
      default: st_next.out.spindle_cmd = alsi_pkg::SPN_STOP;
    endcase

    // Tapping outputs, feed direction from the PLC
    st_next.out.rigid     = st_next.tap != alsi_pkg::TP_IDLE;
    st_next.out.z_feed    = st_next.tap == alsi_pkg::TP_FEED;
    st_next.out.z_retract = st_next.tap == alsi_pkg::TP_RET;
    if (st_next.tap == alsi_pkg::TP_FEED) begin
      st_next.out.feed_dir = plc_in.spindle_dir;
    end else if (st_next.tap == alsi_pkg::TP_RET) begin
      st_next.out.feed_dir = !plc_in.spindle_dir;
    end else begin
      st_next.out.feed_dir = 1'b0;
    end

    // Lock status mirror
    st_next.out.lock_status = plc_in.lock;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg              <= '0;
      st_reg.fn           <= alsi_pkg::FN_IDLE;
      st_reg.tap          <= alsi_pkg::TP_IDLE;
      st_reg.ctrl         <= alsi_pkg::CTRL_RST;
      st_reg.gmax1        <= alsi_pkg::GMAX1_RST;
      st_reg.gmax2        <= alsi_pkg::GMAX2_RST;
      st_reg.gmax3        <= alsi_pkg::GMAX3_RST;
      st_reg.hreadyout    <= 1'b1;
      st_reg.out.gear_sel <= 3'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign hreadyout = st_reg.hreadyout;
  assign hrdata    = st_reg.hrdata;
  assign hresp     = st_reg.hresp;
  assign plc_out   = st_reg.out;

endmodule

`default_nettype wire

// >>> alsi_pkg.sv
// Constants, encodings and carriers for the function lock / spindle block.
// Assumes a single 100 MHz clock domain and a word-wide AHB-Lite slave.
`default_nettype none
package alsi_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_CMD       = 8'h04;
  localparam logic [7:0] OFF_GMAX1     = 8'h08;
  localparam logic [7:0] OFF_GMAX2     = 8'h0C;
  localparam logic [7:0] OFF_GMAX3     = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  localparam logic [7:0] OFF_TAP       = 8'h18;
  localparam logic [7:0] OFF_LOCK_BYTE = 8'h1C;
  localparam logic [7:0] OFF_GFB_BYTE  = 8'h20;
  localparam logic [7:0] OFF_OVR_BYTE  = 8'h24;
  localparam logic [7:0] OFF_STB_BYTE  = 8'h28;
  localparam logic [7:0] OFF_GSEL_BYTE = 8'h2C;

  // ==========================================================================
  // Field positions and reset values
  localparam int CTRL_AUTO   = 0;
  localparam int CTRL_REMOTE = 1;
  localparam int CTRL_ANALOG = 2;
  localparam int CTRL_MANUAL = 3;
  localparam int CTRL_OVR_EN = 4;
  localparam int CTRL_TAPCYC = 5;
  localparam int CTRL_THREAD = 6;
  localparam int CTRL_GEAR3  = 7;
  localparam int ST_ALARM    = 1;
  localparam int TAP_START   = 0;
  localparam int TAP_STEP    = 1;
  localparam int TAP_REVERSE = 2;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [16:0] GMAX1_RST = 17'h003E8;
  localparam logic [16:0] GMAX2_RST = 17'h007D0;
  localparam logic [16:0] GMAX3_RST = 17'h00FA0;

  // ==========================================================================
  // Command kinds, codes and scaling figures
  localparam logic [1:0]  KIND_M      = 2'h1;
  localparam logic [1:0]  KIND_S      = 2'h2;
  localparam logic [1:0]  KIND_T      = 2'h3;
  localparam logic [7:0]  CODE_M03    = 8'h03;
  localparam logic [7:0]  CODE_M00    = 8'h00;
  localparam logic [7:0]  CODE_M01    = 8'h01;
  localparam logic [7:0]  CODE_M02    = 8'h02;
  localparam logic [7:0]  CODE_M30    = 8'h1E;
  localparam logic [7:0]  CODE_M98    = 8'h62;
  localparam logic [7:0]  CODE_M99    = 8'h63;
  localparam logic [16:0] S_GEAR_MAX  = 17'h00008;
  localparam logic [6:0]  OVR_BASE    = 7'h32;
  localparam logic [6:0]  OVR_STEP    = 7'h0A;
  localparam logic [6:0]  OVR_FIXED   = 7'h64;
  localparam logic [23:0] PCT_DIV     = 24'h000064;
  localparam logic [11:0] DAC_FULL    = 12'hFFF;
  localparam logic [1:0]  SPN_STOP    = 2'h0;
  localparam logic [1:0]  SPN_FWD     = 2'h1;
  localparam logic [1:0]  SPN_REV     = 2'h2;

  // ==========================================================================
  // State encodings
  typedef enum logic [2:0] {
    FN_IDLE = 3'b001, FN_STROBE = 3'b010, FN_RELEASE = 3'b100
  } alsi_fn_t;

  typedef enum logic [7:0] {
    TP_IDLE = 8'b00000001, TP_ROT  = 8'b00000010, TP_FEED = 8'b00000100,
    TP_STOP = 8'b00001000, TP_WAIT = 8'b00010000, TP_REV  = 8'b00100000,
    TP_RET  = 8'b01000000, TP_END  = 8'b10000000
  } alsi_tap_t;

  // ==========================================================================
  // Carriers toward and from the PLC
  typedef struct packed {
    logic       lock;
    logic [2:0] ovr_code;
    logic [2:0] gear_fb;
    logic       gear_inpos;
    logic       done;
    logic       spindle_dir;
    logic       spindle_stopped;
  } alsi_plc_in_t;

  typedef struct packed {
    logic        lock_status;
    logic [7:0]  m_code;
    logic        m_strobe;
    logic [3:0]  m_enc;
    logic [7:0]  s_gear;
    logic        s_strobe;
    logic [7:0]  t_code;
    logic        t_strobe;
    logic [2:0]  gear_sel;
    logic [11:0] analog;
    logic        rigid;
    logic        feed_dir;
    logic        z_feed;
    logic        z_retract;
    logic [1:0]  spindle_cmd;
    logic        alarm;
  } alsi_plc_out_t;

endpackage
`default_nettype wire

// >>> alsi_top_monitor.sv
// Port checker for alsi_top: bus wait state, strobes, gear and tapping.
// Assumes one hclk domain with hresetn low as its reset.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module alsi_top_monitor (
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire alsi_pkg::alsi_plc_in_t  plc_in,
  input wire alsi_pkg::alsi_plc_out_t plc_out
);
  // One clock, reset disables every check
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase, then one wait state
  sequence rd_addr;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_wait: assert property (rd_addr |=> rd_wait)
    else $error("read wait state wrong");
  chk_lock_mirror: assert property (
    plc_out.lock_status == $past(plc_in.lock))
    else $error("lock status differs from lock");
  chk_strobe_hold: assert property (
    plc_out.m_strobe && !plc_in.done |=> plc_out.m_strobe)
    else $error("strobe dropped before done");
  chk_strobe_clear: assert property (
    plc_out.m_strobe && plc_in.done |=> !plc_out.m_strobe)
    else $error("strobe stayed after done");
  chk_sub_quiet: assert property (
    plc_out.m_strobe |-> plc_out.m_code != alsi_pkg::CODE_M98
      && plc_out.m_code != alsi_pkg::CODE_M99)
    else $error("subprogram code was output");
  chk_gear_onehot: assert property ($onehot0(plc_out.s_gear))
    else $error("gear address not one-hot");
  chk_sel_onehot: assert property ($onehot(plc_out.gear_sel))
    else $error("gear select not one-hot");
  // Tapping opens with rotation, then feed
  sequence tap_open;
    plc_out.spindle_cmd != alsi_pkg::SPN_STOP ##1 plc_out.z_feed;
  endsequence
  chk_tap_start: assert property (
    $rose(plc_out.rigid) |-> tap_open)
    else $error("tapping start steps wrong");
  chk_feed_dir: assert property (
    plc_out.z_feed |-> plc_out.feed_dir == $past(plc_in.spindle_dir))
    else $error("feed direction wrong");
endmodule
bind alsi_top alsi_top_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .plc_in(plc_in), .plc_out(plc_out));
`default_nettype wire

// >>> alsi_plc_model.sv
// Behavioural PLC on the far side of the alsi_top plc ports.
// Assumes the bench sets lock, override, direction and reply lag.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// PLC model
module alsi_plc_model (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    lock,
  input  wire logic                    dir,
  input  wire logic [2:0]              ovr,
  input  wire logic [3:0]              lag,
  input  wire alsi_pkg::alsi_plc_out_t plc_out,
  output var  alsi_pkg::alsi_plc_in_t  plc_in
);
  logic [3:0] wait_cnt;
  logic [2:0] stop_cnt;
  logic       any_stb;
  // Any code output waiting for completion
  assign any_stb = plc_out.m_strobe | plc_out.s_strobe | plc_out.t_strobe;
  // Inputs change only just after a rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      plc_in <= '0;
      wait_cnt <= 4'h0;
      stop_cnt <= 3'h0;
    end else begin
      plc_in.lock <= lock;
      plc_in.ovr_code <= ovr;
      plc_in.gear_fb <= plc_out.gear_sel;
      plc_in.gear_inpos <= plc_in.gear_fb == plc_out.gear_sel;
      plc_in.spindle_dir <= dir;
      wait_cnt <= (any_stb && !plc_in.done) ? wait_cnt + 4'h1 : 4'h0;
      plc_in.done <= any_stb && (plc_in.done || wait_cnt >= lag);
      stop_cnt <= (plc_out.spindle_cmd != alsi_pkg::SPN_STOP) ? 3'h0 :
        stop_cnt + {2'h0, stop_cnt != 3'h7};
      plc_in.spindle_stopped <= stop_cnt > 3'h3; // Spindle coasts down
    end
  end
endmodule
`default_nettype wire

// >>> alsi_top_tb.sv
// Self-checking bench for alsi_top with a behavioural PLC partner.
// Assumes a 100 MHz hclk; the bench is the only AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("FAIL %s exp %h got %h", n, e, g); end end
// ==========================================================
// Bench
module alsi_top_tb;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        lock;
    logic [2:0]  ovr;
    logic [31:0] cmd;
    logic [2:0]  stb;
    logic [3:0]  enc;
    logic [2:0]  gsel;
  } alsi_row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        lock_k = 1'b0;
  logic        dir_k = 1'b1;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  ovr_k = 3'h0;
  logic [3:0]  lag_k = 4'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  int          bad_count = 0;
  int          num_checks = 0;
  alsi_pkg::alsi_plc_in_t  plc_in;
  alsi_pkg::alsi_plc_out_t plc_out;
  alsi_row_t   rows [22] = '{
    '{8'h01,1'h0,3'h0,32'h10000005,3'h4,4'h0,3'h1},
    '{8'h01,1'h1,3'h0,32'h10000005,3'h0,4'h0,3'h1},
    '{8'h02,1'h1,3'h0,32'h30000007,3'h0,4'h0,3'h1},
    '{8'h08,1'h1,3'h0,32'h20000003,3'h0,4'h0,3'h1},
    '{8'h01,1'h1,3'h0,32'h10000000,3'h4,4'h8,3'h1},
    '{8'h01,1'h1,3'h0,32'h10000001,3'h4,4'h4,3'h1},
    '{8'h01,1'h1,3'h0,32'h10000002,3'h4,4'h2,3'h1},
    '{8'h01,1'h1,3'h0,32'h10000003,3'h4,4'h0,3'h1},
    '{8'h01,1'h1,3'h0,32'h10000062,3'h0,4'h0,3'h1},
    '{8'h01,1'h0,3'h0,32'h10000063,3'h0,4'h0,3'h1},
    '{8'h01,1'h0,3'h0,32'h1000001E,3'h4,4'h1,3'h1},
    '{8'h00,1'h1,3'h0,32'h30000007,3'h1,4'h0,3'h1},
    '{8'h00,1'h0,3'h0,32'h20000001,3'h2,4'h0,3'h1},
    '{8'h00,1'h0,3'h0,32'h20000008,3'h2,4'h0,3'h1},
    '{8'h00,1'h0,3'h0,32'h20000009,3'h0,4'h0,3'h1},
    '{8'h15,1'h1,3'h0,32'h20000320,3'h0,4'h0,3'h1},
    '{8'h15,1'h0,3'h7,32'h20000320,3'h2,4'h0,3'h1},
    '{8'h35,1'h0,3'h7,32'h20000320,3'h2,4'h0,3'h1},
    '{8'h55,1'h0,3'h7,32'h20000320,3'h2,4'h0,3'h1},
    '{8'h05,1'h0,3'h7,32'h200005DC,3'h2,4'h0,3'h2},
    '{8'h85,1'h0,3'h3,32'h200005DC,3'h2,4'h0,3'h2},
    '{8'h85,1'h0,3'h0,32'h200009C4,3'h2,4'h0,3'h4}};
  // Clock, single-slave ready and the parts under test
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  alsi_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .plc_in(plc_in), .plc_out(plc_out));
  alsi_plc_model partner (.hclk(hclk), .hresetn(hresetn), .lock(lock_k),
    .dir(dir_k), .ovr(ovr_k), .lag(lag_k), .plc_out(plc_out),
    .plc_in(plc_in));
  // One AHB single word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // Expected analog code from command, override and gear maximum
  function automatic logic [11:0] exp_an(alsi_row_t r);
    logic [31:0] pct;
    logic [31:0] gm;
    logic [31:0] v;
    pct = (r.ctrl[4] && !r.ctrl[5] && !r.ctrl[6]) ?
      alsi_pkg::OVR_BASE + alsi_pkg::OVR_STEP * r.ovr : alsi_pkg::OVR_FIXED;
    gm = r.gsel[0] ? alsi_pkg::GMAX1_RST :
      r.gsel[1] ? alsi_pkg::GMAX2_RST : alsi_pkg::GMAX3_RST;
    v = r.cmd[16:0] * pct / 32'h64 * 32'hFFF / gm;
    if (!r.ctrl[2]) return 12'h000;
    return (v > 32'hFFF) ? 12'hFFF : v[11:0];
  endfunction
  // Counts, verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    finish_test();
  end
  // Main sequence: reset, table of commands, then awkward cases
  initial begin
    alsi_row_t  r;
    logic [2:0] seen;
    logic [3:0] enc;
    logic [7:0] mc;
    logic [7:0] sg;
    logic [7:0] eg;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("gear_sel rst", 3'h1, plc_out.gear_sel)
    xfer(1'b0, alsi_pkg::OFF_GMAX1, 32'h0);
    `CHK("gmax1 rst", {15'h0, alsi_pkg::GMAX1_RST}, q)
    xfer(1'b1, 8'h30, 32'hFFFFFFFF);
    xfer(1'b0, 8'h30, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("hresp", 1'b0, hresp)
    foreach (rows[i]) begin
      r = rows[i];
      lock_k <= r.lock;
      ovr_k <= r.ovr;
      lag_k <= i[0] ? 4'h9 : 4'h0;
      xfer(1'b1, alsi_pkg::OFF_CTRL, {24'h0, r.ctrl});
      xfer(1'b1, alsi_pkg::OFF_CMD, r.cmd);
      {seen, enc, mc, sg} = '0;
      repeat (40) begin
        @(posedge hclk);
        seen |= {plc_out.m_strobe, plc_out.s_strobe, plc_out.t_strobe};
        enc |= plc_out.m_enc;
        if (plc_out.m_strobe) mc = plc_out.m_code;
        if (plc_out.t_strobe) mc = plc_out.t_code;
        if (plc_out.s_strobe && !r.ctrl[2]) sg = plc_out.s_gear;
      end
      `CHK("strobes", r.stb, seen)
      `CHK("m_enc", r.enc, enc)
      if (r.stb[2] || r.stb[0]) `CHK("code", r.cmd[7:0], mc)
      eg = (r.stb[1] && !r.ctrl[2]) ? 8'h01 << (r.cmd[2:0] - 3'h1) : 8'h00;
      `CHK("s_gear", eg, sg)
      `CHK("gear_sel", r.gsel, plc_out.gear_sel)
      `CHK("analog", exp_an(r), plc_out.analog)
    end
    `CHK("alarm", 1'b1, plc_out.alarm)
    xfer(1'b1, alsi_pkg::OFF_STATUS, 32'h2);
    xfer(1'b0, alsi_pkg::OFF_STATUS, 32'h0);
    `CHK("alarm clear", 1'b0, q[alsi_pkg::ST_ALARM])
    lag_k <= 4'hF;
    lock_k <= 1'b0;
    xfer(1'b1, alsi_pkg::OFF_CTRL, 32'h1);
    xfer(1'b1, alsi_pkg::OFF_CMD, 32'h10000005);
    lock_k <= 1'b1;
    xfer(1'b0, alsi_pkg::OFF_STATUS, 32'h0);
    `CHK("busy", 1'b1, q[0])
    `CHK("strobe held", 1'b1, plc_out.m_strobe)
    `CHK("lock status", 1'b1, plc_out.lock_status)
    for (int k = 0; k < 60 && plc_out.m_strobe !== 1'b0; k++) @(posedge hclk);
    `CHK("strobe released", 1'b0, plc_out.m_strobe)
    repeat (4) @(posedge hclk);
    xfer(1'b0, alsi_pkg::OFF_STATUS, 32'h0);
    `CHK("done seen", 4'h8, q[3:0] & 4'h9)
    lock_k <= 1'b0;
    xfer(1'b1, alsi_pkg::OFF_TAP, 32'h1);
    for (int k = 0; k < 60 && plc_out.z_feed !== 1'b1; k++) @(posedge hclk);
    `CHK("rigid", 1'b1, plc_out.rigid)
    `CHK("spin fwd", alsi_pkg::SPN_FWD, plc_out.spindle_cmd)
    `CHK("feed dir", dir_k, plc_out.feed_dir)
    xfer(1'b1, alsi_pkg::OFF_TAP, 32'h2);
    for (int k = 0; k < 60 && plc_out.z_retract !== 1'b1; k++) @(posedge hclk);
    `CHK("spin rev", alsi_pkg::SPN_REV, plc_out.spindle_cmd)
    `CHK("back dir", ~dir_k, plc_out.feed_dir)
    xfer(1'b1, alsi_pkg::OFF_TAP, 32'h2);
    repeat (3) @(posedge hclk);
    `CHK("rigid off", 1'b0, plc_out.rigid)
    `CHK("spin stop", alsi_pkg::SPN_STOP, plc_out.spindle_cmd)
    finish_test();
  end
endmodule
`default_nettype wire
